// ---- rwp_group_decode.sv ----
`timescale 1ns/1ns
`default_nettype none
module rwp_group_decode #(
  parameter bit HAS_LPT = 1'b1
) (
  // Word address of the access.
  input wire logic [rwp_pkg::ADDR_W-1:0] addr,
  // Decode result.
  output logic hit,
  output rwp_pkg::rwp_group_type group,
  output logic [rwp_pkg::GIDX_W-1:0] gidx
);
  import rwp_pkg::*;

  logic [ADDR_W-1:0] rel;
  logic [ADDR_W-1:0] end_clk;
  logic [ADDR_W-1:0] end_mp;
  logic [ADDR_W-1:0] end_lpt;
  logic [ADDR_W-1:0] end_vd;

  always_comb begin
    rel = ADDR_W'(addr - IDX_GUARD_BASE);
    end_clk = CNT_CLOCKGEN;
    end_mp = ADDR_W'(end_clk + CNT_MODE_POWER);
    end_lpt = ADDR_W'(end_mp + CNT_LP_TIMER);
    end_vd = ADDR_W'(end_lpt + CNT_VOLT_DETECT);
    gidx = rel[GIDX_W-1:0];
    hit = 1'b0;
    group = RWP_GRP_CLOCKGEN;
    if (addr >= IDX_GUARD_BASE) begin
      if (rel < end_clk) begin
        hit = 1'b1;
        group = RWP_GRP_CLOCKGEN;
      end else if (rel < end_mp) begin
        hit = 1'b1;
        group = RWP_GRP_MODE_POWER;
      end else if (rel < end_lpt) begin
        // Timer registers exist only in the larger variant.
        hit = HAS_LPT;
        group = RWP_GRP_LP_TIMER;
      end else if (rel < end_vd) begin
        hit = 1'b1;
        group = RWP_GRP_VOLT_DETECT;
      end
    end
  end

endmodule // rwp_group_decode
`default_nettype wire

// ---- rwp_pkg.sv ----
`default_nettype none
package rwp_pkg;

  // Avalon-MM word address and data widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = DATA_W / 8;

  // Word indices of the block's own registers and of the guarded window's base.
  localparam logic [ADDR_W-1:0] IDX_PROTECT = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_GUARD_BASE = 8'h10;

  // Guarded register groups, laid out back to back from the base.
  localparam logic [ADDR_W-1:0] CNT_CLOCKGEN = 8'h08;
  localparam logic [ADDR_W-1:0] CNT_MODE_POWER = 8'h0C;
  localparam logic [ADDR_W-1:0] CNT_LP_TIMER = 8'h06;
  localparam logic [ADDR_W-1:0] CNT_VOLT_DETECT = 8'h08;
  localparam int NUM_GUARDED = 34;
  localparam int GIDX_W = 6;

  // Position of the software reset register inside the guarded window.
  localparam logic [GIDX_W-1:0] REL_SW_RESET = 6'h13;

  // Protect register layout.
  localparam int PROT_W = 4;
  localparam logic [PROT_W-1:0] PROT_RESET = 4'h0;
  localparam logic [PROT_W-1:0] PROT_MASK_FULL = 4'hF;
  localparam logic [PROT_W-1:0] PROT_MASK_NO_LPT = 4'hB;

  // Status register layout.
  localparam int STAT_BLOCKED_BIT = 0;
  localparam int STAT_IDX_LSB = 8;
  localparam logic [GIDX_W-1:0] STAT_IDX_RESET = 6'h00;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    RWP_GRP_CLOCKGEN,
    RWP_GRP_MODE_POWER,
    RWP_GRP_LP_TIMER,
    RWP_GRP_VOLT_DETECT
  } rwp_group_type;

  typedef enum logic {
    RWP_BUS_IDLE,
    RWP_BUS_ACK
  } rwp_bus_state_type;

endpackage
`default_nettype wire

// ---- rwp_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module rwp_top #(
  parameter bit HAS_LPT = 1'b1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Avalon-MM slave.
  input wire logic [rwp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rwp_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [rwp_pkg::BE_W-1:0] avs_byteenable,
  output logic [rwp_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Guard levels.
  output logic clockgen_write_guard,
  output logic mode_power_write_guard,
  output logic lowpower_timer_write_guard,
  output logic voltage_detect_write_guard,
  // Event pulses.
  output logic sw_reset_req,
  output logic write_blocked
);
  import rwp_pkg::*;

  // All state lives in one record so that reset and enable treat it alike.
  typedef struct packed {
    rwp_bus_state_type bus;
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
    logic [PROT_W-1:0] protect;
    logic blocked;
    logic [GIDX_W-1:0] blocked_idx;
    logic sw_reset;
    logic block_pulse;
    logic [NUM_GUARDED-1:0][DATA_W-1:0] regs;
  } rwp_state_type;

  localparam logic [PROT_W-1:0] PROT_MASK =
    HAS_LPT ? PROT_MASK_FULL : PROT_MASK_NO_LPT;

  localparam rwp_state_type STATE_RESET = '{
    bus: RWP_BUS_IDLE,
    waitrequest: 1'b1,
    readdata: DATA_ZERO,
    protect: PROT_RESET,
    blocked: 1'b0,
    blocked_idx: STAT_IDX_RESET,
    sw_reset: 1'b0,
    block_pulse: 1'b0,
    regs: '0
  };

  rwp_state_type st_r;
  rwp_state_type st_nxt;
  logic g_hit;
  rwp_group_type g_group;
  logic [GIDX_W-1:0] g_idx;
  logic guard_open;
  logic [DATA_W-1:0] rd_value;
  logic sel_protect;
  logic sel_status;
  logic wr_accept;
  logic wr_drop;
  logic [DATA_W-1:0] wr_merged;
  localparam int BYTE_W = 8;

  ////////////////////////////////////////////////////////////////////////////

  rwp_group_decode #(
    .HAS_LPT(HAS_LPT)
  ) u_decode (
    .addr(avs_address),
    .hit(g_hit),
    .group(g_group),
    .gidx(g_idx)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Own registers are picked out first. The guarded window never overlaps
  // them, so a guarded hit and an own select are never true together.
  always_comb begin
    sel_protect = 1'b0;
    sel_status = 1'b0;
    if (avs_address == IDX_PROTECT) begin
      sel_protect = 1'b1;
    end
    if (avs_address == IDX_STATUS) begin
      sel_status = 1'b1;
    end
  end

  // A guarded write goes through only with its group's bit set.
  always_comb begin
    wr_accept = 1'b0;
    wr_drop = 1'b0;
    if (avs_write && g_hit) begin
      if (guard_open) begin
        wr_accept = 1'b1;
      end else begin
        wr_drop = 1'b1;
      end
    end
  end

  // Lanes left out of the byte enable keep what the register holds.
  for (genvar gb = 0; gb < BE_W; gb++) begin : g_lane
    assign wr_merged[gb*BYTE_W +: BYTE_W] = avs_byteenable[gb] ?
      avs_writedata[gb*BYTE_W +: BYTE_W] : rd_value[gb*BYTE_W +: BYTE_W];
  end

  ////////////////////////////////////////////////////////////////////////////

  // Each group is opened by its own guard bit.
  always_comb begin
    case (g_group)
      RWP_GRP_CLOCKGEN: guard_open = st_r.protect[0];
      RWP_GRP_MODE_POWER: guard_open = st_r.protect[1];
      RWP_GRP_LP_TIMER: guard_open = st_r.protect[2];
      RWP_GRP_VOLT_DETECT: guard_open = st_r.protect[3];
      default: guard_open = 1'b0;
    endcase
  end

  // Reads of guarded registers never depend on the guard bits.
  always_comb begin
    rd_value = DATA_ZERO;
    if (sel_protect) begin
      rd_value[PROT_W-1:0] = st_r.protect;
    end else if (sel_status) begin
      rd_value[STAT_BLOCKED_BIT] = st_r.blocked;
      rd_value[STAT_IDX_LSB +: GIDX_W] = st_r.blocked_idx;
    end else if (g_hit) begin
      rd_value = st_r.regs[g_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // A request is taken on the first enabled edge while idle, and
  // waitrequest drops for exactly the following cycle. Read data and the
  // event pulses are registered at that same edge, so they stand in the
  // answer cycle together with the low waitrequest.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sw_reset = 1'b0;
    st_nxt.block_pulse = 1'b0;
    case (st_r.bus)
      RWP_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt.bus = RWP_BUS_ACK;
          st_nxt.waitrequest = 1'b0;
          st_nxt.readdata = avs_write ? DATA_ZERO : rd_value;
        end
        if (avs_write) begin
          if (avs_address == IDX_PROTECT && avs_byteenable[0]) begin
            // Without the timer option its guard bit stays zero.
            st_nxt.protect =
              avs_writedata[PROT_W-1:0] & PROT_MASK;
          end else if (avs_address == IDX_STATUS && avs_byteenable[0]) begin
            if (avs_writedata[STAT_BLOCKED_BIT]) begin
              st_nxt.blocked = 1'b0;
            end
          end else if (wr_accept) begin
            st_nxt.regs[g_idx] = wr_merged;
            if (g_idx == REL_SW_RESET) begin
              st_nxt.sw_reset = 1'b1;
            end
          end else if (wr_drop) begin
            // Dropped write; the flag is set and this write's index replaces any earlier one.
            st_nxt.blocked = 1'b1;
            st_nxt.blocked_idx = g_idx;
            st_nxt.block_pulse = 1'b1;
          end
        end
      end
      RWP_BUS_ACK: begin
        st_nxt.bus = RWP_BUS_IDLE;
        st_nxt.waitrequest = 1'b1;
      end
      default: begin
        st_nxt.bus = RWP_BUS_IDLE;
        st_nxt.waitrequest = 1'b1;
      end
    endcase
  end

  // Enable low freezes the bus handshake too, so a master must not drop
  // the enable while an answer stands: waitrequest would stay low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= STATE_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Every output is a bit of the state register.
  assign avs_readdata = st_r.readdata;
  assign avs_waitrequest = st_r.waitrequest;
  assign clockgen_write_guard = st_r.protect[0];
  assign mode_power_write_guard = st_r.protect[1];
  assign lowpower_timer_write_guard = st_r.protect[2];
  assign voltage_detect_write_guard = st_r.protect[3];
  assign sw_reset_req = st_r.sw_reset;
  assign write_blocked = st_r.block_pulse;

endmodule // rwp_top
`default_nettype wire

// ---- rwp_top_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module rwp_top_assertions #(
  parameter bit HAS_LPT = 1'b1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Bus.
  input wire logic [rwp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [rwp_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [rwp_pkg::BE_W-1:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Guards and pulses.
  input wire logic clockgen_write_guard,
  input wire logic mode_power_write_guard,
  input wire logic lowpower_timer_write_guard,
  input wire logic voltage_detect_write_guard,
  input wire logic sw_reset_req,
  input wire logic write_blocked
);
  import rwp_pkg::*;
  logic ans;
  logic [3:0] grd;
  assign ans = avs_write && !avs_waitrequest;
  assign grd = {voltage_detect_write_guard, lowpower_timer_write_guard,
                mode_power_write_guard, clockgen_write_guard};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  chk_wait_once: assert property (
    !avs_waitrequest && ce |=> avs_waitrequest) else $error("long answer");
  chk_write_answer: assert property (
    $rose(avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("late answer");
  chk_guard_load: assert property (
    ans && avs_address == IDX_PROTECT && avs_byteenable[0] |-> grd ==
    (avs_writedata[3:0] & (HAS_LPT ? PROT_MASK_FULL : PROT_MASK_NO_LPT)))
    else $error("guard load");
  chk_guard_hold: assert property (
    $changed(grd) |-> ans && avs_address == IDX_PROTECT)
    else $error("guard moved");
  chk_clk_group: assert property (
    ans && avs_address inside {[8'h10:8'h17]} |-> write_blocked == !grd[0])
    else $error("clock group");
  chk_mode_group: assert property (
    ans && avs_address inside {[8'h18:8'h23]} |-> write_blocked == !grd[1])
    else $error("mode group");
  chk_timer_group: assert property (
    ans && avs_address inside {[8'h24:8'h29]} |->
    write_blocked == (HAS_LPT && !grd[2])) else $error("timer group");
  chk_volt_group: assert property (
    ans && avs_address inside {[8'h2A:8'h31]} |-> write_blocked == !grd[3])
    else $error("voltage group");
  chk_sw_reset: assert property (
    sw_reset_req == (ans && avs_address == 8'h23 && grd[1]))
    else $error("reset request");
endmodule // rwp_top_assertions
bind rwp_top rwp_top_assertions #(.HAS_LPT(HAS_LPT)) u_chk (.clk, .nrst,
  .ce, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .clockgen_write_guard, .mode_power_write_guard,
  .lowpower_timer_write_guard, .voltage_detect_write_guard, .sw_reset_req,
  .write_blocked);
`default_nettype wire

// ---- rwp_top_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module rwp_top_bench;
  import rwp_pkg::*;
  logic clk, nrst, ce, avs_read, avs_write, avs_waitrequest, blk, swr;
  logic swr_w, blk_w;
  logic [ADDR_W-1:0] avs_address, a;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, d, q;
  logic [BE_W-1:0] avs_byteenable;
  logic [3:0] grd;
  logic [7:0] base [4];
  logic [7:0] cnt [4];
  logic [31:0] mem [NUM_GUARDED];
  int r;
  int n_errors = 0;
  int cmp_count = 0;
  integer seed = 32'h9E80ED4C;
  rwp_top dut (.clk, .nrst, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .clockgen_write_guard(grd[0]), .mode_power_write_guard(grd[1]),
    .lowpower_timer_write_guard(grd[2]),
    .voltage_detect_write_guard(grd[3]), .sw_reset_req(swr_w),
    .write_blocked(blk_w));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h saw %h", nm, e, s);
    end
  endtask
  // One bus cycle; pulses are taken at the edge that sees the answer.
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd);
    int n = 0;
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      close_out();
    end
    q = avs_readdata;
    blk = blk_w;
    swr = swr_w;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] stat_exp(input logic [7:0] ad);
    return {18'h0, ad[5:0] - IDX_GUARD_BASE[5:0], 8'h01};
  endfunction
  // Lanes left out of the byte enable keep their old byte.
  function automatic logic [31:0] merge(input logic [31:0] o, nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) if (be[i]) o[i*8 +: 8] = nw[i*8 +: 8];
    return o;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    ce = 1'b1;
    avs_byteenable = 4'hF;
    cnt = '{CNT_CLOCKGEN, CNT_MODE_POWER, CNT_LP_TIMER, CNT_VOLT_DETECT};
    base[0] = IDX_GUARD_BASE;
    foreach (mem[i]) mem[i] = '0;
    for (int i = 0; i < 3; i++) base[i+1] = base[i] + cnt[i];
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    xfer(1'b0, IDX_PROTECT, 0);
    check("protect", q, 0);
    xfer(1'b1, 8'h05, 32'hFFFF_FFFF);
    check("unmapped flag", blk, 0);
    xfer(1'b0, 8'h05, 0);
    check("unmapped", q, 0);
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 2; k++) begin
        a = 8'($unsigned($random(seed)) % cnt[g]);
        a = base[g] + (k ? cnt[g] - 8'h01 : a);
        r = a - IDX_GUARD_BASE;
        d = $random(seed);
        xfer(1'b1, a, d);
        check("blocked", blk, 1);
        check("reset held", swr, 0);
        xfer(1'b0, a, 0);
        check("dropped", q, mem[r]);
        xfer(1'b0, IDX_STATUS, 0);
        check("status", q, stat_exp(a));
        xfer(1'b1, IDX_STATUS, 1);
        xfer(1'b0, IDX_STATUS, 0);
        check("cleared", q, stat_exp(a) ^ 32'h1);
        xfer(1'b1, IDX_PROTECT, 32'(4'h1 << g));
        check("guards", grd, 4'h1 << g);
        // The second write of a group leaves lanes 1 and 3 alone.
        avs_byteenable <= k ? 4'h5 : 4'hF;
        xfer(1'b1, a, d);
        avs_byteenable <= 4'hF;
        mem[r] = merge(mem[r], d, k ? 4'h5 : 4'hF);
        check("accepted", blk, 0);
        check("reset req", swr, a == 8'h23);
        xfer(1'b1, IDX_PROTECT, 0);
        xfer(1'b0, a, 0);
        check("stored", q, mem[r]);
      end
    end
    // Enable held low: the request waits and is taken once it rises.
    ce <= 1'b0;
    fork
      xfer(1'b1, IDX_PROTECT, 32'h0000_000F);
      begin
        repeat (4) @(posedge clk);
        check("frozen", grd, 0);
        ce <= 1'b1;
      end
    join
    check("all guards", grd, PROT_MASK_FULL);
    // Reset in mid-run clears the guards and the guarded registers.
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    check("reset guards", grd, 0);
    nrst <= 1'b1;
    @(posedge clk);
    xfer(1'b0, IDX_GUARD_BASE, 0);
    check("reset regs", q, 0);
    close_out();
  end
endmodule // rwp_top_bench
`default_nettype wire
